// ==== rtl/sac_ctrl.sv ====
`default_nettype none

module sac_ctrl #(
	parameter int unsigned BIT_CYCLES = sac_pkg::DEF_BIT_CYC
) (
	input  wire logic                            clk_i,
	input  wire logic                            sys_rst_i,
	input  wire logic                            reset_pin_n_i,
	input  wire logic                            cs_n_i,
	input  wire logic                            wr_n_i,
	input  wire logic                            rd_n_i,
	input  wire logic                            byte_select_i,
	input  wire logic                            twos_complement_select_n_i,
	input  wire logic [sac_pkg::RESULT_BITS-1:0] analog_code_i,
	output logic                                 busy_o,
	output logic                                 data_ready_o,
	output logic      [sac_pkg::BYTE_BITS-1:0]   data_o,
	output logic                                 data_oe_o,
	output logic                                 serial_strobe_o,
	output logic                                 serial_data_o
);
	import sac_pkg::*;

	// ------------------------------------------------------------
	// Constants
	// ------------------------------------------------------------
	// Bit period must be at least two cycles so the strobe can fall
	localparam logic [CNT_W-1:0] BIT_MAX  = CNT_W'(BIT_CYCLES - 1);
	localparam logic [CNT_W-1:0] BIT_HALF = BIT_MAX >> 1;
	localparam logic [CNT_W-1:0] START_LD = CNT_W'(BUSY_CYC - 2);
	localparam logic [CNT_W-1:0] SETTLE_LD = CNT_W'(SETTLE_CYC - 1);
	localparam logic [CNT_W-1:0] CNT_ONE  = 8'h01;
	localparam logic [IDX_W-1:0] IDX_ONE  = 4'h1;

	localparam sac_regs_t REGS_RST = '{
		st: ST_UNINIT, cnt: CNT_RST, idx: MSB_IDX,
		sar: WORD_RST, hold: WORD_RST, latch: WORD_RST,
		busy: 1'b1, ready: 1'b0, wr_q: 1'b1,
		strobe: 1'b0, sdata: 1'b0, dout: BYTE_RST
	};

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	// One-hot mask of the bit under decision
	function automatic logic [RESULT_BITS-1:0] bit_mask(
		input logic [IDX_W-1:0] idx
	);
		logic [RESULT_BITS-1:0] m;
		m = WORD_RST;
		m[idx] = 1'b1;
		return m;
	endfunction

	// Offset binary held inside; twos complement flips the top bit
	function automatic logic [RESULT_BITS-1:0] fmt(
		input logic [RESULT_BITS-1:0] v,
		input logic                   tc_n
	);
		return {v[RESULT_BITS-1] ^ ~tc_n, v[RESULT_BITS-2:0]};
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	sac_regs_t              s;        // Registered state
	sac_regs_t              next_s;   // Next state
	logic                   start_ev; // Write falling edge, selected
	logic                   cmd_lvl;  // Start command held
	logic                   rd_act;   // Parallel read in progress
	logic                   rd_hi;    // High byte read
	logic                   fin;      // Conversion finishes now
	logic                   accept;   // Start taken this cycle
	logic [RESULT_BITS-1:0] trial;    // Trial approximation
	logic [RESULT_BITS-1:0] shown;    // Latch in output format
	logic                   keep;     // Trial bit kept

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	// All decisions in one place so the struct has one driver
	always_comb begin
		next_s = s;
		trial  = s.sar | bit_mask(s.idx);
		keep   = s.hold >= trial;
		shown  = fmt(s.latch, twos_complement_select_n_i);
		// Chip select high masks every strobe
		start_ev = !cs_n_i && !wr_n_i && s.wr_q;
		cmd_lvl  = !cs_n_i && !wr_n_i;
		rd_act   = !cs_n_i && !rd_n_i;
		rd_hi    = rd_act && !byte_select_i;
		fin      = 1'b0;
		accept   = 1'b0;
		next_s.wr_q = wr_n_i;
		case (s.st)
			ST_UNINIT: begin
				// Status stays high; starts refused until reset pin
				next_s.busy = 1'b1;
			end
			ST_IDLE: begin
				// An idle converter takes a start; ST_BITS also takes a held command at finish
				if (start_ev) begin
					accept = 1'b1;
				end
			end
			ST_START: begin
				if (s.cnt == CNT_RST) begin
					next_s.st   = ST_SETTLE;
					next_s.busy = 1'b1;
					next_s.cnt  = SETTLE_LD;
				end else begin
					next_s.cnt = s.cnt - CNT_ONE;
				end
			end
			ST_SETTLE: begin
				// Starts in this phase and the next are dropped, bar a command held low at finish
				if (s.cnt == CNT_RST) begin
					next_s.st  = ST_BITS;
					next_s.cnt = BIT_MAX;
					next_s.idx = MSB_IDX;
				end else begin
					next_s.cnt = s.cnt - CNT_ONE;
				end
			end
			ST_BITS: begin
				if (s.cnt == BIT_MAX) begin
					// Decide one bit and present it serially
					if (keep) begin
						next_s.sar = trial;
					end
					next_s.strobe = 1'b1;
					next_s.sdata  = (s.idx == MSB_IDX) ?
						keep ^ ~twos_complement_select_n_i : keep;
				end
				if (s.cnt == BIT_HALF) begin
					// Falling edge with the bit stable
					next_s.strobe = 1'b0;
				end
				if (s.cnt == CNT_RST) begin
					if (s.idx == WORD_RST[IDX_W-1:0]) begin
						fin          = 1'b1;
						next_s.latch = s.sar;
						next_s.ready = 1'b1;
						next_s.busy  = 1'b0;
						next_s.st    = ST_IDLE;
						// Held command restarts here; busy looped to write restarts from idle
						accept = cmd_lvl;
					end else begin
						next_s.idx = s.idx - IDX_ONE;
						next_s.cnt = BIT_MAX;
					end
				end else begin
					next_s.cnt = s.cnt - CNT_ONE;
				end
			end
			default: begin
				next_s.st = ST_IDLE;
			end
		endcase
		// Conversion start: sample the input and clear the register
		if (accept) begin
			next_s.st   = ST_START;
			next_s.cnt  = START_LD;
			next_s.hold = analog_code_i;
			next_s.sar  = WORD_RST;
		end
		// Reads never touch the latch; only the high byte clears
		if (rd_act) begin
			next_s.dout = byte_select_i ?
				shown[BYTE_BITS-1:0] :
				shown[RESULT_BITS-1:BYTE_BITS];
		end
		// A new result wins over a clear in the same cycle
		if (rd_hi && !fin) begin
			next_s.ready = 1'b0;
		end
		// Reset pin aborts everything and arms the converter
		if (!reset_pin_n_i) begin
			next_s       = REGS_RST;
			next_s.st    = ST_IDLE;
			next_s.busy  = 1'b0;
			next_s.wr_q  = wr_n_i;
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// System reset models power-up: status comes up high
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			s <= REGS_RST;
		end else begin
			s <= next_s;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign busy_o          = s.busy;
	assign data_ready_o    = s.ready;
	assign data_o          = s.dout;
	assign serial_strobe_o = s.strobe;
	assign serial_data_o   = s.sdata;
	// Enable follows the pins; the byte itself is a flop behind
	assign data_oe_o       = rd_act;

	// ------------------------------------------------------------
	// Assertion helpers
	// ------------------------------------------------------------
	localparam int A_BUSY = BUSY_CYC;
	localparam int A_RISE = BUSY_CYC - 1; // Delay after two low samples
	localparam int A_DEC  = FIRST_DEC_CYC + 1;
	logic [FALL_W-1:0] falls;      // Strobe falls this conversion
	logic              strobe_fall; // Strobe falls at next edge

	assign strobe_fall = s.strobe && !next_s.strobe;

	// Count falls, restarted while a start is pending
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || s.st == ST_START) begin
			falls <= '0;
		end else if (strobe_fall) begin
			falls <= falls + FALL_W'(1);
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	AST_RESET_CLEARS: assert property (
		!reset_pin_n_i |=> !busy_o && !data_ready_o && !serial_strobe_o)
		else $error("reset pin did not clear status");

	AST_NO_START_UNARMED: assert property (
		(s.st == ST_UNINIT && reset_pin_n_i) |=> busy_o && s.sar == 16'h0)
		else $error("conversion ran before reset pin");

	AST_BUSY_RISE: assert property (
		disable iff (sys_rst_i || !reset_pin_n_i)
		(s.st == ST_IDLE && accept) |->
		(!busy_o [*2]) ##[A_RISE:A_RISE] $rose(busy_o))
		else $error("busy did not rise on time");

	AST_FIRST_DECISION: assert property (
		disable iff (sys_rst_i || !reset_pin_n_i)
		(s.st == ST_IDLE && accept) |-> ##[A_DEC:A_DEC] $rose(serial_strobe_o))
		else $error("first decision off time");

	AST_BUSY_FALL_DATA: assert property (
		fin && reset_pin_n_i |=> !busy_o && data_ready_o &&
		s.latch == $past(s.sar))
		else $error("finish did not latch result");

	AST_READY_HOLDS: assert property (
		(data_ready_o && reset_pin_n_i && !rd_hi) |=> data_ready_o)
		else $error("data ready dropped without high read");

	AST_LATCH_STABLE: assert property (
		(!fin && reset_pin_n_i) |=> $stable(s.latch))
		else $error("latch changed without a finish");

	AST_HIGH_READ: assert property (
		(rd_hi && !fin && reset_pin_n_i) |=> !data_ready_o &&
		data_o == $past(shown[15:8]))
		else $error("high byte read wrong");

	AST_LOW_READ: assert property (
		(rd_act && byte_select_i && data_ready_o && reset_pin_n_i) |=>
		data_ready_o && data_o == $past(shown[7:0]))
		else $error("low byte read wrong");

	AST_SIXTEEN_FALLS: assert property (
		fin && reset_pin_n_i |=> falls == BITS_PER_WORD)
		else $error("serial strobe edge count wrong");

	AST_DESELECT_NOP: assert property (
		(cs_n_i && s.st == ST_IDLE && reset_pin_n_i) |=>
		s.st == ST_IDLE && $stable(data_o))
		else $error("activity while deselected");

	AST_IGNORE_BUSY: assert property (
		((s.st == ST_SETTLE || s.st == ST_BITS) && start_ev && !fin &&
		reset_pin_n_i) |=> s.st != ST_START && $stable(s.hold))
		else $error("start taken while converting");

	AST_RETRIGGER: assert property (
		(fin && cmd_lvl && reset_pin_n_i) |=> s.st == ST_START)
		else $error("held command did not restart");

	AST_FORMAT_MSB: assert property (
		(rd_hi && reset_pin_n_i) |=> data_o[7] ==
		($past(s.latch[15]) ^ !$past(twos_complement_select_n_i)))
		else $error("output code format wrong");

	COV_CONTINUOUS: cover property (
		fin && cmd_lvl ##1 s.st == ST_START);
	COV_READ_BOTH: cover property (
		rd_hi ##[1:20] (rd_act && byte_select_i));
	COV_READ_DURING: cover property (
		busy_o && rd_hi && s.st == ST_BITS);
	COV_OVERWRITE: cover property (
		fin && data_ready_o);

endmodule

`default_nettype wire

// ==== rtl/sac_pkg.sv ====
`default_nettype none

package sac_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS     = 8;   // 125 MHz system clock
	localparam int BUSY_DELAY_NS     = 110; // Start to busy high
	localparam int FIRST_DECISION_NS = 900; // Start to first decision
	localparam int BUSY_CYC      =
		(BUSY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FIRST_DEC_CYC =
		(FIRST_DECISION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_CYC    = FIRST_DEC_CYC - BUSY_CYC;
	localparam int DEF_BIT_CYC   = 8;   // Cycles per result bit

	// ------------------------------------------------------------
	// Widths and positions
	// ------------------------------------------------------------
	localparam int RESULT_BITS = 16;
	localparam int BYTE_BITS   = 8;
	localparam int CNT_W       = 8;
	localparam int IDX_W       = 4;
	localparam int FALL_W      = 5;
	localparam logic [IDX_W-1:0] MSB_IDX = 4'hf;
	localparam logic [FALL_W-1:0] BITS_PER_WORD = 5'h10;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [RESULT_BITS-1:0] WORD_RST = 16'h0000;
	localparam logic [BYTE_BITS-1:0]   BYTE_RST = 8'h00;
	localparam logic [CNT_W-1:0]       CNT_RST  = 8'h00;

	// ------------------------------------------------------------
	// Control states
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_UNINIT = 5'h01, // Powered up, waiting for reset pin
		ST_IDLE   = 5'h02, // Ready for a start
		ST_START  = 5'h04, // Start taken, busy not yet high
		ST_SETTLE = 5'h08, // Busy high, before first decision
		ST_BITS   = 5'h10  // Bit decisions and serial output
	} sac_state_t;

	typedef struct packed {
		sac_state_t             st;     // Control state
		logic [CNT_W-1:0]       cnt;    // Phase timer
		logic [IDX_W-1:0]       idx;    // Bit under decision
		logic [RESULT_BITS-1:0] sar;    // Approximation register
		logic [RESULT_BITS-1:0] hold;   // Held input code
		logic [RESULT_BITS-1:0] latch;  // Output data latch
		logic                   busy;   // Status
		logic                   ready;  // Data ready flag
		logic                   wr_q;   // Write strobe last cycle
		logic                   strobe; // Serial data strobe
		logic                   sdata;  // Serial data bit
		logic [BYTE_BITS-1:0]   dout;   // Parallel output byte
	} sac_regs_t;

endpackage

`default_nettype wire

// ==== bench/sac_serial_rx.sv ====
`default_nettype none
// ----------------------------------------------------------
// Serial shift register on the far side of the converter
// ----------------------------------------------------------
module sac_serial_rx (
	input  wire logic        strobe_i, // Serial data strobe
	input  wire logic        sdata_i,  // Serial data bit
	input  wire logic        sync_i,   // Word sync taken from status
	output logic      [15:0] word_o,   // Word shifted in, MSB first
	output logic      [4:0]  falls_o   // Strobe falls since last sync
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] total; // All strobe falls seen
	logic [7:0] base;  // Fall count at the last sync
	initial begin
		total = 8'h00;
		base = 8'h00;
		word_o = 16'h0000;
	end
	// Capture on the falling edge, where the bit is stable
	always @(negedge strobe_i) begin
		word_o <= {word_o[14:0], sdata_i};
		total <= total + 8'h01;
	end
	// Status rising marks the start of a new word
	always @(posedge sync_i) begin
		base <= total;
	end
	assign falls_o = 5'(total - base);
endmodule
`default_nettype wire

// ==== bench/sac_ctrl_test.sv ====
`default_nettype none
module sac_ctrl_test;
	timeunit 1ns;
	timeprecision 100ps;
	import sac_pkg::*;
	// ------------------------------------------------------
	// Signals
	// ------------------------------------------------------
	localparam int BC = 2; // Short bit period keeps runs brief
	logic        clk, sys_rst, reset_pin_n, cs_n, wr_n, rd_n;
	logic        byte_select, tc_n, busy, ready, oe, strobe, sdata;
	logic [15:0] code, rx_word;
	logic [7:0]  data;
	logic [4:0]  rx_falls;
	int          err_count, cmp_count;
	sac_ctrl #(.BIT_CYCLES(BC)) DUT (.clk_i(clk), .sys_rst_i(sys_rst),
		.reset_pin_n_i(reset_pin_n), .cs_n_i(cs_n), .wr_n_i(wr_n),
		.rd_n_i(rd_n), .byte_select_i(byte_select),
		.twos_complement_select_n_i(tc_n), .analog_code_i(code),
		.busy_o(busy), .data_ready_o(ready), .data_o(data),
		.data_oe_o(oe), .serial_strobe_o(strobe), .serial_data_o(sdata));
	sac_serial_rx rx (.strobe_i(strobe), .sdata_i(sdata), .sync_i(busy),
		.word_o(rx_word), .falls_o(rx_falls));
	always #4 clk = ~clk;
	// ------------------------------------------------------
	// Compare and bus tasks
	// ------------------------------------------------------
	task automatic chk_word(input logic [15:0] g, e, input string m);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task automatic chk_byte(input logic [7:0] g, e, input string m);
		chk_word({8'h00, g}, {8'h00, e}, m);
	endtask
	task automatic chk_bit(input logic g, e, input string m);
		chk_word({15'h0000, g}, {15'h0000, e}, m);
	endtask
	task automatic chk_cnt(input int g, e, input string m);
		chk_word(16'(g), 16'(e), m);
	endtask
	task automatic end_of_test();
		if (err_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Start on a write fall; time busy and the first strobe
	task automatic start(input logic [15:0] v);
		int n;
		@(posedge clk);
		code <= v;
		cs_n <= 1'h0;
		wr_n <= 1'h0;
		@(posedge clk);
		wr_n <= 1'h1;
		// Count from the edge that launched the write strobe fall
		n = 1;
		while (busy !== 1'h1 && n < 40) begin
			@(posedge clk);
			#1 n++;
		end
		chk_cnt(n, BUSY_CYC, "busy delay");
		while (strobe !== 1'h1 && n < 200) begin
			@(posedge clk);
			#1 n++;
		end
		chk_cnt(n, FIRST_DEC_CYC + 1, "first decision");
	endtask
	// Bounded wait for busy high, then low; result must be flagged
	task automatic done();
		int n;
		n = 0;
		while (busy !== 1'h1 && n < 40) begin
			@(posedge clk);
			#1 n++;
		end
		while (busy !== 1'h0 && n < 400) begin
			@(posedge clk);
			#1 n++;
		end
		chk_bit(busy, 1'h0, "busy stuck");
		chk_bit(ready, 1'h1, "ready not set");
	endtask
	// Read after completion, the quiet time for the host
	task automatic rd(input logic b, input logic [7:0] e, input logic r);
		@(posedge clk);
		cs_n <= 1'h0;
		rd_n <= 1'h0;
		byte_select <= b;
		@(posedge clk);
		#1 chk_bit(oe, 1'h1, "driver off in read");
		@(posedge clk);
		#1 chk_byte(data, e, "read byte");
		chk_bit(ready, r, "ready after read");
		@(posedge clk);
		cs_n <= 1'h1;
		rd_n <= 1'h1;
		#1 chk_bit(oe, 1'h0, "driver on idle");
	endtask
	// ------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------
	task automatic t_reset();
		@(posedge clk);
		reset_pin_n <= 1'h0;
		@(posedge clk);
		#1 chk_bit(busy, 1'h0, "busy after reset");
		chk_bit(ready, 1'h0, "ready after reset");
		reset_pin_n <= 1'h1;
	endtask
	task automatic t_basic();
		start(16'hc35a);
		done();
		chk_word(rx_word, 16'hc35a, "serial word");
		chk_cnt(rx_falls, 16, "strobe falls");
		rd(1'h1, 8'h5a, 1'h1);
		rd(1'h0, 8'hc3, 1'h0);
		rd(1'h0, 8'hc3, 1'h0);
		tc_n <= 1'h0;
		start(16'h0123);
		done();
		chk_word(rx_word, 16'h8123, "serial twos");
		rd(1'h1, 8'h23, 1'h1);
		rd(1'h0, 8'h81, 1'h0);
		tc_n <= 1'h1;
	endtask
	// Mid-conversion start is ignored; unread word is overwritten
	task automatic t_overrun();
		start(16'h1111);
		code <= 16'h2222;
		wr_n <= 1'h0;
		@(posedge clk);
		wr_n <= 1'h1;
		done();
		rd(1'h1, 8'h11, 1'h1);
		start(16'h3333);
		done();
		rd(1'h1, 8'h33, 1'h1);
	endtask
	// Deselected strobes do nothing, ready stays set
	task automatic t_deselect();
		@(posedge clk);
		cs_n <= 1'h1;
		wr_n <= 1'h0;
		rd_n <= 1'h0;
		byte_select <= 1'h0;
		repeat (30) @(posedge clk);
		#1 chk_bit(oe, 1'h0, "driver on deselected");
		chk_bit(busy, 1'h0, "start while deselected");
		chk_bit(ready, 1'h1, "ready lost deselected");
		wr_n <= 1'h1;
		rd_n <= 1'h1;
	endtask
	// Write and high-byte read in the same cycle
	task automatic t_both();
		@(posedge clk);
		code <= 16'h4242;
		cs_n <= 1'h0;
		wr_n <= 1'h0;
		rd_n <= 1'h0;
		@(posedge clk);
		wr_n <= 1'h1;
		@(posedge clk);
		#1 chk_byte(data, 8'h33, "joint read byte");
		chk_bit(ready, 1'h0, "joint read ready");
		rd_n <= 1'h1;
		done();
		rd(1'h0, 8'h42, 1'h0);
	endtask
	// Held command restarts; status fed to write converts forever
	task automatic t_held();
		int n;
		@(posedge clk);
		cs_n <= 1'h0;
		wr_n <= 1'h0;
		done();
		n = 0;
		while (busy !== 1'h1 && n < 20) begin
			@(posedge clk);
			#1 n++;
		end
		chk_bit(busy, 1'h1, "no restart on held");
		wr_n <= 1'h1;
		done();
		n = 0;
		repeat (600) begin
			@(posedge clk);
			wr_n <= busy;
			#1 if (busy === 1'h0 && wr_n === 1'h1) n++;
		end
		chk_bit(n >= 3, 1'h1, "continuous mode");
		wr_n <= 1'h1;
		done();
	endtask
	// Reset pin in mid-conversion aborts it
	task automatic t_abort();
		start(16'h5555);
		t_reset();
		repeat (200) @(posedge clk);
		#1 chk_bit(ready, 1'h0, "abort finished anyway");
		chk_bit(busy, 1'h0, "abort busy");
	endtask
	// ------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------
	initial begin
		{clk, reset_pin_n, cs_n, wr_n, rd_n, tc_n} = 6'h1f;
		clk = 1'h0;
		sys_rst = 1'h1;
		byte_select = 1'h0;
		code = 16'h0000;
		err_count = 0;
		cmp_count = 0;
		repeat (3) @(posedge clk);
		sys_rst <= 1'h0;
		@(posedge clk);
		cs_n <= 1'h0;
		wr_n <= 1'h0;
		repeat (200) @(posedge clk);
		#1 chk_bit(ready, 1'h0, "start before arming");
		wr_n <= 1'h1;
		t_reset();
		t_basic();
		t_overrun();
		t_deselect();
		t_both();
		t_held();
		t_abort();
		end_of_test();
	end
	initial begin
		#100000;
		err_count++;
		end_of_test();
	end
endmodule
`default_nettype wire
